// File: rtl/gfs_pkg.sv
package gfs_pkg;
    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] GFS_OFS_SEL3 = 8'h0C;
    localparam logic [7:0] GFS_OFS_SEL4 = 8'h10;
    localparam logic [7:0] GFS_OFS_SEL5 = 8'h14;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int GFS_FIELD_W = 3;
    localparam int GFS_SEL3_PINS = 10;
    localparam int GFS_SEL4_PINS = 10;
    localparam int GFS_SEL5_PINS = 4;
    localparam int GFS_PINS = 24;
    localparam int GFS_SEL3_W = 30;
    localparam int GFS_SEL4_W = 30;
    localparam int GFS_SEL5_W = 12;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [29:0] GFS_SEL3_RST = 30'h0000_0000;
    localparam logic [29:0] GFS_SEL4_RST = 30'h0000_0000;
    localparam logic [11:0] GFS_SEL5_RST = 12'h000;

    // ------------------------------------------------------------
    // selection codes
    // ------------------------------------------------------------
    localparam logic [2:0] GFS_CODE_IN = 3'h0;
    localparam logic [2:0] GFS_CODE_OUT = 3'h1;
    localparam logic [2:0] GFS_CODE_ALT5 = 3'h2;
    localparam logic [2:0] GFS_CODE_ALT4 = 3'h3;
    localparam logic [2:0] GFS_CODE_ALT0 = 3'h4;
    localparam logic [2:0] GFS_CODE_ALT1 = 3'h5;
    localparam logic [2:0] GFS_CODE_ALT2 = 3'h6;
    localparam logic [2:0] GFS_CODE_ALT3 = 3'h7;

    // alternate function numbers
    localparam logic [2:0] GFS_ALT_0 = 3'h0;
    localparam logic [2:0] GFS_ALT_1 = 3'h1;
    localparam logic [2:0] GFS_ALT_2 = 3'h2;
    localparam logic [2:0] GFS_ALT_3 = 3'h3;
    localparam logic [2:0] GFS_ALT_4 = 3'h4;
    localparam logic [2:0] GFS_ALT_5 = 3'h5;
endpackage

// File: rtl/gfs_function_select.sv
// How it works
// (RULE_01) code 000 input, 001 output
// (RULE_02) codes 100-111 pick alternate functions 0-3
// (RULE_03) code 011 alternate 4, 010 alternate 5
// (RULE_04) all fields read-write, reset to zero
// (RULE_05) register 4: pins 40-49, bits 31-30 zero
// (RULE_06) register 5: pins 50-53, bits 31-12 zero
// (RULE_07) register 3: pin 30 bits 2-0, 31 bits 5-3
// (RULE_08) writes to reserved bits are dropped
`timescale 1ns/1ps
module gfs_function_select (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    // per pin function, bit 0 is pin 30, bit 23 is pin 53; pinAltSel has 3 bits per pin, bits 2-0 pin 30, bits 71-69 pin 53
    output logic [gfs_pkg::GFS_PINS-1:0] pinInput,
    output logic [gfs_pkg::GFS_PINS-1:0] pinOutput,
    output logic [gfs_pkg::GFS_PINS-1:0] pinAltEn,
    output logic [3*gfs_pkg::GFS_PINS-1:0] pinAltSel
);
    import gfs_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [GFS_SEL3_W-1:0] sel3;
        logic [GFS_SEL4_W-1:0] sel4;
        logic [GFS_SEL5_W-1:0] sel5;
        logic [31:0] rdData;
        logic [GFS_PINS-1:0] isIn;
        logic [GFS_PINS-1:0] isOut;
        logic [GFS_PINS-1:0] altEn;
        logic [3*GFS_PINS-1:0] altSel;
    } gfs_state_t;

    gfs_state_t state_q;
    gfs_state_t state_d;
    logic [3*GFS_PINS-1:0] allFields;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    function automatic logic [2:0] altNumber(input logic [2:0] code);
        case (code)
            GFS_CODE_ALT0: altNumber = GFS_ALT_0; // [RULE_02]
            GFS_CODE_ALT1: altNumber = GFS_ALT_1; // [RULE_02]
            GFS_CODE_ALT2: altNumber = GFS_ALT_2; // [RULE_02]
            GFS_CODE_ALT3: altNumber = GFS_ALT_3; // [RULE_02]
            GFS_CODE_ALT4: altNumber = GFS_ALT_4; // [RULE_03]
            GFS_CODE_ALT5: altNumber = GFS_ALT_5; // [RULE_03]
            default: altNumber = GFS_ALT_0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        // only field bits are stored, so reserved bits cannot be set
        if (regWrite) begin
            case (regAddr)
                GFS_OFS_SEL3: state_d.sel3 = regWrData[GFS_SEL3_W-1:0]; // [RULE_07] [RULE_08]
                GFS_OFS_SEL4: state_d.sel4 = regWrData[GFS_SEL4_W-1:0]; // [RULE_05] [RULE_08]
                GFS_OFS_SEL5: state_d.sel5 = regWrData[GFS_SEL5_W-1:0]; // [RULE_06] [RULE_08]
                default: ;
            endcase
        end
        // read data stand only in the cycle after the strobe
        state_d.rdData = 32'h0000_0000;
        if (regRead) begin
            case (regAddr)
                GFS_OFS_SEL3: state_d.rdData = {2'h0, state_q.sel3}; // [RULE_04]
                GFS_OFS_SEL4: state_d.rdData = {2'h0, state_q.sel4}; // [RULE_05]
                GFS_OFS_SEL5: state_d.rdData = {20'h0_0000, state_q.sel5}; // [RULE_06]
                default: state_d.rdData = 32'h0000_0000;
            endcase
        end
        // decoded outputs track the new fields in the same edge
        allFields = {state_d.sel5, state_d.sel4, state_d.sel3};
        for (int i = 0; i < GFS_PINS; i++) begin
            state_d.isIn[i] = (allFields[3*i +: 3] == GFS_CODE_IN); // [RULE_01]
            state_d.isOut[i] = (allFields[3*i +: 3] == GFS_CODE_OUT); // [RULE_01]
            state_d.altEn[i] = allFields[3*i +: 3] != GFS_CODE_IN
                && allFields[3*i +: 3] != GFS_CODE_OUT; // [RULE_02] [RULE_03]
            state_d.altSel[3*i +: 3] = altNumber(allFields[3*i +: 3]);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q.sel3 <= GFS_SEL3_RST; // [RULE_04]
            state_q.sel4 <= GFS_SEL4_RST; // [RULE_04]
            state_q.sel5 <= GFS_SEL5_RST; // [RULE_04]
            state_q.rdData <= 32'h0000_0000;
            state_q.isIn <= {GFS_PINS{1'b1}};
            state_q.isOut <= {GFS_PINS{1'b0}};
            state_q.altEn <= {GFS_PINS{1'b0}};
            state_q.altSel <= {3*GFS_PINS{1'b0}};
        end else begin
            state_q <= state_d;
        end
    end

    assign regRdData = state_q.rdData;
    assign pinInput = state_q.isIn;
    assign pinOutput = state_q.isOut;
    assign pinAltEn = state_q.altEn;
    assign pinAltSel = state_q.altSel;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    exactly_one_a: assert property (@(posedge clk) disable iff (rst)
        (pinInput ^ pinOutput ^ pinAltEn) == {GFS_PINS{1'b1}}
        && (pinInput & pinOutput) == {GFS_PINS{1'b0}})
        else $error("pin function not exactly one"); // [RULE_01]
    pin30_out_a: assert property (@(posedge clk) disable iff (rst)
        regWrite && regAddr == GFS_OFS_SEL3 && regWrData[2:0] == 3'h1 |=> pinOutput[0])
        else $error("pin 30 not output after 001"); // [RULE_01] [RULE_07]
    alt_code_a: assert property (@(posedge clk) disable iff (rst)
        regWrite && regAddr == GFS_OFS_SEL4 && regWrData[29:27] == 3'h6
        |=> pinAltEn[19] && pinAltSel[59:57] == 3'h2)
        else $error("pin 49 code 110 not alternate 2"); // [RULE_02] [RULE_05]
    alt_four_five_a: assert property (@(posedge clk) disable iff (rst)
        regWrite && regAddr == GFS_OFS_SEL5 && regWrData[11:9] == 3'h2
        |=> pinAltEn[23] && pinAltSel[71:69] == 3'h5)
        else $error("pin 53 code 010 not alternate 5"); // [RULE_03] [RULE_06]
    // checked on the first edge after release, so the unreset start-up state is never seen
    reset_input_a: assert property (@(posedge clk)
        $past(rst) && !rst |-> pinInput == {GFS_PINS{1'b1}} && regRdData == 32'h0000_0000)
        else $error("pins not inputs after reset"); // [RULE_04]
    readback_a: assert property (@(posedge clk) disable iff (rst)
        regWrite && regAddr == GFS_OFS_SEL3 ##1 regRead && regAddr == GFS_OFS_SEL3
        |=> regRdData[29:0] == $past(regWrData, 2)
        [29:0])
        else $error("register 3 readback mismatch"); // [RULE_04] [RULE_07]
    sel4_resv_a: assert property (@(posedge clk) disable iff (rst)
        $past(regRead) && $past(regAddr) == GFS_OFS_SEL4 |-> regRdData[31:30] == 2'h0)
        else $error("register 4 reserved bits nonzero"); // [RULE_05] [RULE_08]
    sel5_resv_a: assert property (@(posedge clk) disable iff (rst)
        $past(regRead) && $past(regAddr) == GFS_OFS_SEL5
        |-> regRdData[31:12] == 20'h0_0000)
        else $error("register 5 reserved bits nonzero"); // [RULE_06] [RULE_08]
    no_read_zero_a: assert property (@(posedge clk) disable iff (rst)
        !regRead |=> regRdData == 32'h0000_0000)
        else $error("read data outside read cycle"); // [RULE_04]

    // ------------------------------------------------------------
    // per pin decode checks
    // ------------------------------------------------------------
    // pin outputs are registered from the next fields, so at any edge they match the held fields
    logic [3*GFS_PINS-1:0] heldFields;
    assign heldFields = {state_q.sel5, state_q.sel4, state_q.sel3};

    for (genvar p = 0; p < GFS_PINS; p++) begin : g_pin_chk
        in_code_a: assert property (@(posedge clk) disable iff (rst)
            pinInput[p] == (heldFields[3*p +: 3] == GFS_CODE_IN))
            else $error("pin input flag disagrees with field"); // [RULE_01]
        out_code_a: assert property (@(posedge clk) disable iff (rst)
            pinOutput[p] == (heldFields[3*p +: 3] == GFS_CODE_OUT))
            else $error("pin output flag disagrees with field"); // [RULE_01]
        alt_four_a: assert property (@(posedge clk) disable iff (rst)
            heldFields[3*p +: 3] == GFS_CODE_ALT4
            |-> pinAltEn[p] && pinAltSel[3*p +: 3] == GFS_ALT_4)
            else $error("code 011 not alternate 4"); // [RULE_03]
        alt_zero_a: assert property (@(posedge clk) disable iff (rst)
            heldFields[3*p +: 3] == GFS_CODE_ALT0
            |-> pinAltEn[p] && pinAltSel[3*p +: 3] == GFS_ALT_0)
            else $error("code 100 not alternate 0"); // [RULE_02]
        alt_idle_a: assert property (@(posedge clk) disable iff (rst)
            !pinAltEn[p] |-> pinAltSel[3*p +: 3] == GFS_ALT_0)
            else $error("alternate number set on plain pin"); // [RULE_01]
    end
endmodule // gfs_function_select

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin badCount++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_top;
    import gfs_pkg::*;
    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdData;
    logic [GFS_PINS-1:0] pinInput, pinOutput, pinAltEn, eIn, eOut, eAlt;
    logic [3*GFS_PINS-1:0] pinAltSel, eSel;
    logic [2:0] fld [GFS_PINS];
    logic [2:0] code3;
    // 0x18 and 0x00 are unmapped: writes must vanish, reads give zero
    logic [7:0] addrs [5] = '{GFS_OFS_SEL3, GFS_OFS_SEL4, GFS_OFS_SEL5, 8'h18, 8'h00};
    int badCount = 0;
    int cmpCount = 0;

    gfs_function_select u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .pinInput(pinInput),
        .pinOutput(pinOutput), .pinAltEn(pinAltEn), .pinAltSel(pinAltSel));

    initial forever #50 clk = ~clk;

    // ------------------------------------------------------------
    // model and bus tasks
    // ------------------------------------------------------------
    function automatic int baseOf(logic [7:0] a);
        return a == GFS_OFS_SEL3 ? 0 : a == GFS_OFS_SEL4 ? 10 : a == GFS_OFS_SEL5 ? 20 : -1;
    endfunction
    function automatic int numOf(logic [7:0] a);
        return a == GFS_OFS_SEL5 ? 4 : 10;
    endfunction
    function automatic logic [31:0] expRd(logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (baseOf(a) >= 0) for (int i = 0; i < numOf(a); i++) r[3*i+:3] = fld[baseOf(a)+i];
        return r;
    endfunction
    task automatic chkPins();
        for (int i = 0; i < GFS_PINS; i++) begin
            eIn[i] = (fld[i] == 3'h0);
            eOut[i] = (fld[i] == 3'h1);
            eAlt[i] = (fld[i] >= 3'h2);
            eSel[3*i+:3] = fld[i][2] ? {1'b0, fld[i][1:0]} :
                (fld[i] == 3'h3 ? 3'h4 : fld[i] == 3'h2 ? 3'h5 : 3'h0);
        end
        `CHK(pinInput, eIn)
        `CHK(pinOutput, eOut)
        `CHK(pinAltEn, eAlt)
        `CHK(pinAltSel, eSel)
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        if (baseOf(a) >= 0) for (int i = 0; i < numOf(a); i++) fld[baseOf(a)+i] = d[3*i+:3];
        #1 chkPins();
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 `CHK(regRdData, expRd(a))
        @(posedge clk);
        #1 `CHK(regRdData, 32'h0000_0000)
    endtask
    task automatic rdAll();
        for (int k = 0; k < 5; k++) rd(addrs[k]);
    endtask
    task automatic doReset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (fld[i]) fld[i] = 3'h0;
        #1 chkPins();
    endtask
    task automatic completeRun();
        $display("compares %0d, mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h7ce5));
        foreach (fld[i]) fld[i] = 3'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1 chkPins();
        rdAll();
        // every code on every pin, reserved bits 31-30 written as ones
        for (int c = 0; c < 8; c++) begin
            code3 = c[2:0];
            for (int k = 0; k < 5; k++) wr(addrs[k], {2'b11, {10{code3}}});
            rdAll();
        end
        repeat (60) begin
            wr(addrs[$urandom_range(0, 4)], $urandom());
            rd(addrs[$urandom_range(0, 4)]);
        end
        // write then read with no gap: the read must see the new value
        repeat (8) begin
            @(posedge clk);
            regAddr <= GFS_OFS_SEL3;
            regWrData <= $urandom();
            regWrite <= 1'b1;
            @(posedge clk);
            regWrite <= 1'b0;
            regRead <= 1'b1;
            for (int i = 0; i < 10; i++) fld[i] = regWrData[3*i+:3];
            @(posedge clk);
            regRead <= 1'b0;
            #1 `CHK(regRdData, expRd(GFS_OFS_SEL3))
            chkPins();
        end
        // reset in mid-run must bring every pin back to input
        doReset();
        rdAll();
        completeRun();
    end
    initial begin
        repeat (100000) @(posedge clk);
        badCount++;
        completeRun();
    end
endmodule // tb_top
